/* design/pmc_pkg.sv */
package pmc_pkg;
   // minimum host reset pulse, in ns, and derived cycles at 50 MHz
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned RST_MIN_NS = 1000;
   localparam int unsigned RST_MIN_CYC =
      (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // cycles the management interface needs to initialise
   localparam int unsigned INIT_CYC = 64;
   localparam int unsigned CNT_W = 16;
   localparam logic [2:0] SYNC_RST = 3'h7;

   typedef enum logic [1:0] {
      PMC_LOW_POWER,
      PMC_HIGH_POWER
   } pmc_power_e;

   typedef struct packed {
      logic init_pending;
      logic high_power;
      logic fault_seen;
   } pmc_status_s;
endpackage : pmc_pkg

/* design/pmc_ctrl.sv */
`timescale 1ns/100ps
// What this block does
// - answer management bus only while module select is low
// - host starts every management access; module only serves it
// - reset held low past minimum length restores all defaults
// - completion shown by interrupt low with init pending cleared
// - same completion interrupt raised after power-up, no reset needed
// - undriven init-mode input reads high, selecting software control
// - init-mode high: stay low power until software enables high
// - init-mode low: go high power once management init finishes
// - present line grounded by module; low means fitted
// - interrupt pulled low for faults or critical status
// - interrupt is open-collector: pull low or release only
module pmc_ctrl #(
   parameter int unsigned RST_MIN = pmc_pkg::RST_MIN_CYC,
   parameter int unsigned INIT_LEN = pmc_pkg::INIT_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic module_select_n,
   input wire logic module_reset_n,
   input wire logic init_control_select,
   input wire logic init_control_select_oe,
   input wire logic mgmt_bus_active,
   input wire logic sw_high_power_req,
   input wire logic fault_event,
   input wire logic int_ack,
   output logic mgmt_bus_enable,
   output logic module_present_n,
   output logic interrupt_out_n,
   output logic interrupt_out_oe,
   output logic config_reset,
   output pmc_pkg::pmc_status_s status,
   output pmc_pkg::pmc_power_e power_mode
);
   import pmc_pkg::*;

   // three-stage synchronisers for pin inputs
   logic [2:0] sel_sync_r, sel_sync_nxt;
   logic [2:0] rstn_sync_r, rstn_sync_nxt;
   logic [2:0] mode_sync_r, mode_sync_nxt;
   logic sel_n_r, sel_n_nxt;
   logic rstn_r, rstn_nxt;
   logic mode_r, mode_nxt;
   logic mode_pin;

   // internal pull-up when host leaves pin undriven
   assign mode_pin = init_control_select_oe ? init_control_select : 1'b1;

   always_comb begin
      sel_sync_nxt = {sel_sync_r[1:0], module_select_n};
      rstn_sync_nxt = {rstn_sync_r[1:0], module_reset_n};
      mode_sync_nxt = {mode_sync_r[1:0], mode_pin};
      sel_n_nxt = sel_n_r;
      rstn_nxt = rstn_r;
      mode_nxt = mode_r;
      if (sel_sync_r[2] == sel_sync_r[1]) begin
         sel_n_nxt = sel_sync_r[2];
      end
      if (rstn_sync_r[2] == rstn_sync_r[1]) begin
         rstn_nxt = rstn_sync_r[2];
      end
      if (mode_sync_r[2] == mode_sync_r[1]) begin
         mode_nxt = mode_sync_r[2];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sel_sync_r <= SYNC_RST;
         rstn_sync_r <= SYNC_RST;
         mode_sync_r <= SYNC_RST;
         sel_n_r <= 1'b1;
         rstn_r <= 1'b1;
         mode_r <= 1'b1;
      end else begin
         sel_sync_r <= sel_sync_nxt;
         rstn_sync_r <= rstn_sync_nxt;
         mode_sync_r <= mode_sync_nxt;
         sel_n_r <= sel_n_nxt;
         rstn_r <= rstn_nxt;
         mode_r <= mode_nxt;
      end
   end

   // bus gating; host remains the only initiator
   assign mgmt_bus_enable = ~sel_n_r;

   // present line simply grounded by the module
   assign module_present_n = 1'b0;

   // reset pulse measurement and init sequencing
   logic [CNT_W-1:0] low_cnt_r, low_cnt_nxt;
   logic [CNT_W-1:0] init_cnt_r, init_cnt_nxt;
   logic pending_r, pending_nxt;
   logic cfg_rst_r, cfg_rst_nxt;
   logic done_int_r, done_int_nxt;
   logic fault_int_r, fault_int_nxt;
   logic sw_hp_r, sw_hp_nxt;
   pmc_power_e pwr_r, pwr_nxt;
   logic long_low;
   logic long_hold;

   assign long_low = (low_cnt_r >= CNT_W'(RST_MIN));
   // reset pin held low past the minimum length
   assign long_hold = !rstn_r && long_low;

   always_comb begin
      low_cnt_nxt = low_cnt_r;
      init_cnt_nxt = init_cnt_r;
      pending_nxt = pending_r;
      cfg_rst_nxt = 1'b0;
      done_int_nxt = done_int_r;
      fault_int_nxt = fault_int_r;
      sw_hp_nxt = sw_hp_r;
      pwr_nxt = pwr_r;
      if (!rstn_r) begin
         if (!long_low) begin
            low_cnt_nxt = low_cnt_r + CNT_W'(1);
         end
      end else begin
         low_cnt_nxt = '0;
      end
      if (!rstn_r && long_low) begin
         // full reset: all settings back to default
         cfg_rst_nxt = 1'b1;
         pending_nxt = 1'b1;
         init_cnt_nxt = '0;
         done_int_nxt = 1'b0;
         fault_int_nxt = 1'b0;
         sw_hp_nxt = 1'b0;
         pwr_nxt = PMC_LOW_POWER;
      end else begin
         if (int_ack) begin
            done_int_nxt = 1'b0;
            fault_int_nxt = 1'b0;
         end
         // completion set wins over a same-cycle acknowledge
         if (pending_r) begin
            if (init_cnt_r >= CNT_W'(INIT_LEN - 1)) begin
               pending_nxt = 1'b0;
               done_int_nxt = 1'b1;
            end else begin
               init_cnt_nxt = init_cnt_r + CNT_W'(1);
            end
         end
         // a new event wins over a same-cycle acknowledge
         if (fault_event) begin
            fault_int_nxt = 1'b1;
         end
         if (sw_high_power_req && !pending_r) begin
            sw_hp_nxt = 1'b1;
         end
         unique case (pwr_r)
            PMC_LOW_POWER: begin
               if (!pending_r && (!mode_r || sw_hp_r)) begin
                  pwr_nxt = PMC_HIGH_POWER;
               end
            end
            PMC_HIGH_POWER: begin
               if (mode_r && !sw_hp_r) begin
                  pwr_nxt = PMC_LOW_POWER;
               end
            end
            default: pwr_nxt = PMC_LOW_POWER;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         low_cnt_r <= '0;
         init_cnt_r <= '0;
         pending_r <= 1'b1;
         cfg_rst_r <= 1'b0;
         done_int_r <= 1'b0;
         fault_int_r <= 1'b0;
         sw_hp_r <= 1'b0;
         pwr_r <= PMC_LOW_POWER;
      end else begin
         low_cnt_r <= low_cnt_nxt;
         init_cnt_r <= init_cnt_nxt;
         pending_r <= pending_nxt;
         cfg_rst_r <= cfg_rst_nxt;
         done_int_r <= done_int_nxt;
         fault_int_r <= fault_int_nxt;
         sw_hp_r <= sw_hp_nxt;
         pwr_r <= pwr_nxt;
      end
   end

   // open collector: pin only ever driven low
   assign interrupt_out_n = 1'b0;
   assign interrupt_out_oe = done_int_r | fault_int_r;
   assign config_reset = cfg_rst_r;
   assign status = '{init_pending: pending_r, high_power:
                     (pwr_r == PMC_HIGH_POWER), fault_seen: fault_int_r};
   assign power_mode = pwr_r;

   // select gating and present line checks
   bus_gate_a: assert property (@(posedge clk) disable iff (rst)
      !sel_sync_r[2] && !sel_sync_r[1] |=> mgmt_bus_enable)
      else $error("bus not enabled while selected");
   bus_off_a: assert property (@(posedge clk) disable iff (rst)
      sel_sync_r[2] && sel_sync_r[1] |=> !mgmt_bus_enable)
      else $error("bus enabled without select");
   sel_glitch_a: assert property (@(posedge clk) disable iff (rst)
      sel_sync_r[2] != sel_sync_r[1] |=> $stable(mgmt_bus_enable))
      else $error("select glitch reached bus enable");
   bus_idle_a: assert property (@(posedge clk) disable iff (rst)
      mgmt_bus_active && !mgmt_bus_enable |-> sel_n_r)
      else $error("bus traffic served while deselected");
   present_gnd_a: assert property (@(posedge clk) disable iff (rst)
      !module_present_n)
      else $error("present line not grounded");

   // reset pin checks
   long_reset_a: assert property (@(posedge clk) disable iff (rst)
      long_hold |=> config_reset)
      else $error("long reset not applied");
   short_low_a: assert property (@(posedge clk) disable iff (rst)
      !long_hold |=> !config_reset)
      else $error("reset applied without long low");
   cfg_quiet_a: assert property (@(posedge clk) disable iff (rst)
      config_reset |-> !interrupt_out_oe && !sw_hp_r && !status.high_power)
      else $error("settings not back to default");
   pending_set_a: assert property (@(posedge clk) disable iff (rst)
      config_reset |-> pending_r)
      else $error("pending not set by reset");
   low_sat_a: assert property (@(posedge clk) disable iff (rst)
      low_cnt_r <= CNT_W'(RST_MIN))
      else $error("reset low counter overran");
   init_sat_a: assert property (@(posedge clk) disable iff (rst)
      init_cnt_r <= CNT_W'(INIT_LEN - 1))
      else $error("init counter overran");
   init_quiet_a: assert property (@(posedge clk) disable iff (rst)
      pending_r |-> !done_int_r)
      else $error("completion flagged while init pending");

   // completion interrupt checks
   done_set_a: assert property (@(posedge clk) disable iff (rst)
      pending_r && init_cnt_r >= CNT_W'(INIT_LEN - 1) && !long_hold
      |=> done_int_r && !pending_r)
      else $error("init end did not post completion");
   done_int_a: assert property (@(posedge clk) disable iff (rst)
      $fell(pending_r) && !$past(config_reset) |-> interrupt_out_oe)
      else $error("no completion interrupt after init");
   done_keep_a: assert property (@(posedge clk) disable iff (rst)
      done_int_r && !int_ack && !long_hold |=> done_int_r)
      else $error("completion dropped without acknowledge");
   ack_done_a: assert property (@(posedge clk) disable iff (rst)
      int_ack && !pending_r && !long_hold |=> !done_int_r)
      else $error("acknowledge did not clear completion");
   powerup_int_a: assert property (@(posedge clk)
      $fell(rst) |-> ##[1:300] interrupt_out_oe)
      else $error("no power-up completion interrupt");

   // power mode checks
   pull_up_a: assert property (@(posedge clk) disable iff (rst)
      !init_control_select_oe [*6] |-> mode_r)
      else $error("undriven init mode not high");
   sw_ignore_a: assert property (@(posedge clk) disable iff (rst)
      pending_r |-> !sw_hp_r)
      else $error("software request taken while pending");
   sw_latch_a: assert property (@(posedge clk) disable iff (rst)
      sw_high_power_req && !pending_r && !long_hold |=> sw_hp_r)
      else $error("software request not latched");
   sw_low_a: assert property (@(posedge clk) disable iff (rst)
      mode_r && !sw_hp_r && $past(mode_r) && $past(!sw_hp_r)
      |=> pwr_r == PMC_LOW_POWER)
      else $error("left low power without software");
   hold_low_a: assert property (@(posedge clk) disable iff (rst)
      pending_r |-> pwr_r == PMC_LOW_POWER)
      else $error("high power before init finished");
   hw_high_a: assert property (@(posedge clk) disable iff (rst)
      !mode_r && !pending_r && !long_hold |=> pwr_r == PMC_HIGH_POWER)
      else $error("hardware mode did not go high power");
   hw_stay_a: assert property (@(posedge clk) disable iff (rst)
      pwr_r == PMC_HIGH_POWER && !mode_r && !long_hold
      |=> pwr_r == PMC_HIGH_POWER)
      else $error("hardware mode left high power");

   // fault interrupt checks
   fault_int_a: assert property (@(posedge clk) disable iff (rst)
      fault_event && !long_hold |=> interrupt_out_oe && !interrupt_out_n)
      else $error("fault not flagged");
   set_wins_a: assert property (@(posedge clk) disable iff (rst)
      fault_event && int_ack && !long_hold |=> fault_int_r)
      else $error("acknowledge beat a new fault");
   fault_keep_a: assert property (@(posedge clk) disable iff (rst)
      fault_int_r && !int_ack && !long_hold |=> fault_int_r)
      else $error("fault dropped without acknowledge");
   ack_clear_a: assert property (@(posedge clk) disable iff (rst)
      int_ack && !fault_event && !pending_r && !long_hold
      |=> !interrupt_out_oe)
      else $error("acknowledge did not release interrupt");
   oe_low_a: assert property (@(posedge clk) disable iff (rst)
      interrupt_out_oe |-> !interrupt_out_n)
      else $error("interrupt driven high");
endmodule : pmc_ctrl

/* test/pmc_host.sv */
`timescale 1ns/100ps
module pmc_host (
   input wire logic interrupt_out_n,
   input wire logic interrupt_out_oe,
   input wire logic module_present_n,
   output logic int_line,
   output logic present_line
);
   // board pull-ups: released lines read high
   assign int_line = interrupt_out_oe ? interrupt_out_n : 1'b1;
   assign present_line = (module_present_n === 1'b0) ? 1'b0 : 1'b1;
endmodule : pmc_host

/* test/tb.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   miscompares++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
   import pmc_pkg::*;
   logic clk = 0, rst = 1, sel_n = 1, rpin_n = 1, ics = 0, ics_oe = 0;
   logic swreq = 0, fault = 0, ack = 0;
   logic bus_en, prs_n, int_n, int_oe, cfg_rst, int_line, prs_line;
   pmc_status_s st;
   pmc_power_e pm;
   int miscompares = 0, n_checks = 0, cyc = 0, cr_cnt = 0, cr0 = 0;
   pmc_ctrl #(.RST_MIN(4), .INIT_LEN(8)) DUT (.clk(clk), .rst(rst),
      .module_select_n(sel_n), .module_reset_n(rpin_n),
      .init_control_select(ics), .init_control_select_oe(ics_oe),
      .mgmt_bus_active(~sel_n), .sw_high_power_req(swreq),
      .fault_event(fault), .int_ack(ack), .mgmt_bus_enable(bus_en),
      .module_present_n(prs_n), .interrupt_out_n(int_n),
      .interrupt_out_oe(int_oe), .config_reset(cfg_rst), .status(st),
      .power_mode(pm));
   pmc_host host (.interrupt_out_n(int_n), .interrupt_out_oe(int_oe),
      .module_present_n(prs_n), .int_line(int_line),
      .present_line(prs_line));
   initial forever #10 clk = ~clk;
   always @(posedge clk) begin
      if (cfg_rst === 1'b1) cr_cnt++;
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         test_done;
      end
   end
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task wait_int;
      int i;
      i = 0;
      while (int_line !== 1'b0 && i < 300) begin
         @(posedge clk);
         i++;
      end
   endtask : wait_int
   task pulse_ack; // host pulses acknowledge for one cycle, then waits two
      ack <= 1'b1;
      tick(1);
      ack <= 1'b0;
      tick(2);
   endtask : pulse_ack
   task t_power_up;
      wait_int;
      `CHK("int_line", 1'b0, int_line)
      `CHK("pending", 1'b0, st.init_pending)
      tick(5);
      `CHK("power_sw", PMC_LOW_POWER, pm)
      `CHK("lp_status", 1'b0, st.high_power)
      swreq <= 1'b1;
      tick(1);
      swreq <= 1'b0;
      tick(3);
      `CHK("power_req", PMC_HIGH_POWER, pm)
      pulse_ack;
      `CHK("int_rel", 1'b1, int_line)
      $display("t_power_up done");
   endtask : t_power_up
   task t_select;
      sel_n <= 1'b0;
      tick(6);
      `CHK("bus_en_on", 1'b1, bus_en)
      sel_n <= 1'b1;
      tick(6);
      `CHK("bus_en_off", 1'b0, bus_en)
      $display("t_select done");
   endtask : t_select
   task t_reset;
      cr0 = cr_cnt;
      rpin_n <= 1'b0;
      tick(2);
      rpin_n <= 1'b1;
      tick(8);
      `CHK("short_rst", 1'b0, (cr_cnt != cr0))
      rpin_n <= 1'b0;
      tick(12);
      `CHK("long_rst", 1'b1, (cr_cnt != cr0))
      `CHK("pend_rst", 1'b1, st.init_pending)
      `CHK("int_rst", 1'b1, int_line)
      rpin_n <= 1'b1;
      wait_int;
      `CHK("pend_done", 1'b0, st.init_pending)
      tick(5);
      `CHK("power_dflt", PMC_LOW_POWER, pm)
      $display("t_reset done");
   endtask : t_reset
   task t_fault;
      pulse_ack;
      fault <= 1'b1;
      tick(1);
      fault <= 1'b0;
      tick(2);
      `CHK("int_fault", 1'b0, int_line)
      `CHK("fault_seen", 1'b1, st.fault_seen)
      pulse_ack;
      `CHK("int_clr", 1'b1, int_line)
      $display("t_fault done");
   endtask : t_fault
   task t_hw_mode;
      rst <= 1'b1;
      ics_oe <= 1'b1;
      tick(4);
      rst <= 1'b0;
      wait_int;
      tick(4);
      `CHK("power_hw", PMC_HIGH_POWER, pm)
      `CHK("hp_status", 1'b1, st.high_power)
      `CHK("present", 1'b0, prs_line)
      $display("t_hw_mode done");
   endtask : t_hw_mode
   task test_done;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done
   initial begin
      tick(16);
      rst <= 1'b0;
      t_power_up;
      t_select;
      t_reset;
      t_fault;
      t_hw_mode;
      test_done;
   end
endmodule : tb
